// ### sgwl_host.sv
`timescale 1ns/10ps
`default_nettype none
module sgwl_host (
   output logic c_out,
   output logic d_out,
   output logic w_out
);
   initial {c_out, d_out, w_out} = 3'b001;
   task send(input logic [15:0] w, input int n);
      w_out = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #3 {c_out, d_out} = {1'b1, w[i]};
         #3 c_out = 1'b0;
      end
      #3 w_out = 1'b1;
      d_out = ~d_out; // released line must not keep its value
   endtask : send
   // window stays high: these pulses must be ignored
   task idle_pulses(input int n);
      for (int i = 0; i < n; i++) begin
         #3 {c_out, d_out} = {1'b1, ~d_out};
         #3 c_out = 1'b0;
      end
   endtask : idle_pulses
endmodule : sgwl_host
`default_nettype wire

// ### sgwl_loader.sv
`timescale 1ns/10ps
`default_nettype none
module sgwl_loader #(
   parameter int unsigned POWERUP_CYCLES = sgwl_pkg::POWERUP_CYC
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic core_en_in,
   input wire logic serial_clk_in,
   input wire logic serial_gain_bit_in,
   input wire logic load_window_n_in,
   input wire logic sleep_request_n_in,
   output logic [sgwl_pkg::GAIN_W-1:0] gain_code_out,
   output logic amp_enable_out,
   output logic output_settled_out,
   output logic write_busy_out
);
   localparam int unsigned GW = sgwl_pkg::GAIN_W;

   // a finished word is taken only once the power-up default has been applied
   function automatic logic take_word(
      input logic rise,
      input logic boot
   );
      take_word = rise & ~boot;
   endfunction : take_word

   // rising edge of a synchronised level, for window and sleep alike
   function automatic logic rose_now(
      input logic now_lvl,
      input logic was_lvl
   );
      rose_now = now_lvl & ~was_lvl;
   endfunction : rose_now

   // link domain: shift register on the falling serial clock
   logic [GW-1:0] shift_q;
   logic [GW-1:0] next_shift;

   // while the window is open every stage moves one place toward the msb
   for (genvar i = 0; i < GW; i++) begin : g_shift
      if (i == 0) begin : g_lsb
         assign next_shift[i] = load_window_n_in ? shift_q[i] : serial_gain_bit_in;
      end else begin : g_upper
         assign next_shift[i] = load_window_n_in ? shift_q[i] : shift_q[i-1];
      end
   end

   // no reset: the stages hold while the window is high between frames and each frame rewrites every bit
   always_ff @(negedge serial_clk_in) begin
      shift_q <= next_shift;
   end

   // core domain: window and sleep pins pass two flops before any decision
   logic win_s1;
   logic win_s2;
   logic win_s3;
   logic slp_s1;
   logic slp_s2;
   logic next_win_s1;
   logic next_win_s2;
   logic next_win_s3;
   logic next_slp_s1;
   logic next_slp_s2;

   always_comb begin
      next_win_s1 = load_window_n_in;
      next_win_s2 = win_s1;
      next_win_s3 = win_s2;
      next_slp_s1 = sleep_request_n_in;
      next_slp_s2 = slp_s1;
   end

   // idle levels after reset, so no false edge follows it
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         win_s1 <= 1'b1;
         win_s2 <= 1'b1;
         win_s3 <= 1'b1;
         slp_s1 <= 1'b1;
         slp_s2 <= 1'b1;
      end else if (core_en_in) begin
         win_s1 <= next_win_s1;
         win_s2 <= next_win_s2;
         win_s3 <= next_win_s3;
         slp_s1 <= next_slp_s1;
         slp_s2 <= next_slp_s2;
      end
   end

   // power-up flag: the first enabled cycle after reset loads the default
   logic powerup_q;
   logic next_powerup;

   always_comb begin
      next_powerup = 1'b0;
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         powerup_q <= 1'b1;
      end else if (core_en_in) begin
         powerup_q <= next_powerup;
      end
   end

   // gain latch
   logic [GW-1:0] gain_q;
   logic [GW-1:0] next_gain;
   logic take_now;

   // a rise inside the power-up cycle is dropped in favour of the default;
   // the word has stood still since the window rose, two core cycles back,
   // because the shift stages hold their bits while the window is high
   assign take_now = take_word(rose_now(win_s2, win_s3), powerup_q);

   always_comb begin
      next_gain = gain_q;
      if (powerup_q) begin
         next_gain = sgwl_pkg::GAIN_MIN;
      end else if (take_now) begin
         next_gain = shift_q;
      end
   end

   // sleep never touches this register, so the code survives it
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         gain_q <= sgwl_pkg::GAIN_MIN;
      end else if (core_en_in) begin
         gain_q <= next_gain;
      end
   end

   // settle tracking
   logic settled_q;
   logic next_settled;
   logic [sgwl_pkg::SETTLE_W-1:0] settle_cnt;
   logic [sgwl_pkg::SETTLE_W-1:0] next_settle_cnt;
   logic slp_prev;
   logic next_slp_prev;
   logic wake_now;
   logic apply_short;

   assign wake_now = rose_now(slp_s2, slp_prev);
   // a longer wake or boot count already running is not cut short by a write
   assign apply_short = settle_cnt <= 16'(sgwl_pkg::APPLY_CYC);

   always_comb begin
      next_settled = settled_q;
      next_settle_cnt = settle_cnt;
      next_slp_prev = slp_s2;
      if (powerup_q) begin
         next_settled = 1'b0;
         next_settle_cnt = 16'(POWERUP_CYCLES);
      end else if (wake_now) begin
         next_settled = 1'b0;
         next_settle_cnt = 16'(sgwl_pkg::WAKE_CYC);
      end else if (!slp_s2) begin
         next_settled = 1'b0;
      end else if (take_now && apply_short) begin
         next_settled = 1'b0;
         next_settle_cnt = 16'(sgwl_pkg::APPLY_CYC);
      end else if (settle_cnt > sgwl_pkg::SETTLE_ONE) begin
         next_settle_cnt = settle_cnt - sgwl_pkg::SETTLE_ONE;
      end else begin
         next_settle_cnt = sgwl_pkg::SETTLE_ZERO;
         next_settled = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         settled_q <= 1'b0;
         settle_cnt <= sgwl_pkg::SETTLE_ZERO;
         slp_prev <= 1'b1;
      end else if (core_en_in) begin
         settled_q <= next_settled;
         settle_cnt <= next_settle_cnt;
         slp_prev <= next_slp_prev;
      end
   end

   // amplifier enable and busy flag
   logic amp_q;
   logic next_amp;
   logic busy_q;
   logic next_busy;

   // the pin is async, so the sync flops cost up to three core cycles
   always_comb begin
      next_amp = slp_s2;
      next_busy = ~win_s2;
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         amp_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (core_en_in) begin
         amp_q <= next_amp;
         busy_q <= next_busy;
      end
   end

   assign gain_code_out = gain_q;
   assign amp_enable_out = amp_q;
   assign output_settled_out = settled_q;
   assign write_busy_out = busy_q;
endmodule : sgwl_loader
`default_nettype wire

// ### sgwl_loader_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sgwl_loader_assertions #(parameter int unsigned POWERUP_CYCLES = 20) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic load_window_n_in,
   input wire logic sleep_request_n_in,
   input wire logic [sgwl_pkg::GAIN_W-1:0] gain_code_out,
   input wire logic amp_enable_out,
   input wire logic output_settled_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   // cycles since reset fell, saturating
   logic [15:0] boot_cnt;
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         boot_cnt <= 16'h0000;
      end else if (boot_cnt != 16'hFFFF) begin
         boot_cnt <= boot_cnt + 16'h0001;
      end
   end
   a_boot_hold: assert property (boot_cnt <= POWERUP_CYCLES |-> !output_settled_out)
      else $error("boot settle too early");
   a_gain_rise: assert property ($changed(gain_code_out) |->
      $past(load_window_n_in, 3) && !$past(load_window_n_in, 4)) else $error("early");
   a_win_idle: assert property (load_window_n_in [*6] |-> $stable(gain_code_out))
      else $error("drift");
   a_sleep_off: assert property ($fell(sleep_request_n_in) |-> ##[1:3] !amp_enable_out)
      else $error("late");
   a_sleep_hold: assert property (!sleep_request_n_in [*4] |-> !amp_enable_out)
      else $error("awake");
   a_wake_amp: assert property (sleep_request_n_in [*5] |-> amp_enable_out)
      else $error("asleep");
   a_dark_idle: assert property (!amp_enable_out |-> !output_settled_out)
      else $error("settled");
   a_gain_settle: assert property ($changed(gain_code_out) && amp_enable_out |->
      !output_settled_out ##1 output_settled_out) else $error("settle");
   a_boot_wait: assert property ($fell(sys_rst_in) |-> !output_settled_out [*8])
      else $error("soon");
   c_wr: cover property ($changed(gain_code_out));
   c_sleep: cover property ($fell(amp_enable_out));
   c_wake: cover property ($rose(output_settled_out));
endmodule : sgwl_loader_assertions
bind sgwl_loader sgwl_loader_assertions #(.POWERUP_CYCLES(POWERUP_CYCLES)) chk_i (.*);
`default_nettype wire

// ### sgwl_pkg.sv
package sgwl_pkg;
   localparam int unsigned GAIN_W = 8;
   localparam int unsigned CNT_W = 4;
   localparam logic [CNT_W-1:0] WORD_BITS = 4'h8;
   localparam logic [GAIN_W-1:0] GAIN_MIN = 8'h00;
   localparam logic [GAIN_W-1:0] GAIN_MSB_FIRST_INIT = 8'h00;
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_MHZ;
   // settling figures in their own units
   localparam int unsigned APPLY_NS = 30;
   localparam int unsigned SLEEP_NS = 45;
   localparam int unsigned WAKE_NS = 45;
   localparam int unsigned POWERUP_US = 200;
   // the ns times round down, at least one cycle
   localparam int unsigned APPLY_CYC_RAW = APPLY_NS / CLK_PERIOD_NS;
   localparam int unsigned APPLY_CYC = (APPLY_CYC_RAW < 1) ? 1 : APPLY_CYC_RAW;
   localparam int unsigned SLEEP_CYC_RAW = SLEEP_NS / CLK_PERIOD_NS;
   localparam int unsigned SLEEP_CYC = (SLEEP_CYC_RAW < 1) ? 1 : SLEEP_CYC_RAW;
   localparam int unsigned WAKE_CYC_RAW = WAKE_NS / CLK_PERIOD_NS;
   localparam int unsigned WAKE_CYC = (WAKE_CYC_RAW < 1) ? 1 : WAKE_CYC_RAW;
   localparam int unsigned POWERUP_CYC = (POWERUP_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_W = 16;
   localparam logic [SETTLE_W-1:0] SETTLE_ONE = 16'h0001;
   localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 16'h0000;
   typedef enum logic [1:0] {
      SGWL_IDLE = 2'b00,
      SGWL_SHIFT = 2'b01,
      SGWL_DONE = 2'b10
   } sgwl_link_t;
endpackage : sgwl_pkg

// ### test_serial_gain_word_loader.sv
`timescale 1ns/10ps
`default_nettype none
module test_serial_gain_word_loader;
   logic core_clk_in = 1'b0, sys_rst_in = 1'b1, sleep_request_n_in = 1'b1, write_busy_out;
   logic serial_clk_in, serial_gain_bit_in, load_window_n_in, amp_enable_out, output_settled_out;
   logic [7:0] gain_code_out;
   int fails = 0, checks = 0;
   logic core_en_in = 1'b1;
   wire logic [10:0] st = {write_busy_out, amp_enable_out, output_settled_out, gain_code_out};
   sgwl_loader #(.POWERUP_CYCLES(20)) sgwl_loader_i (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .core_en_in(core_en_in),
      .serial_clk_in(serial_clk_in),
      .serial_gain_bit_in(serial_gain_bit_in),
      .load_window_n_in(load_window_n_in),
      .sleep_request_n_in(sleep_request_n_in),
      .gain_code_out(gain_code_out),
      .amp_enable_out(amp_enable_out),
      .output_settled_out(output_settled_out),
      .write_busy_out(write_busy_out)
   );
   sgwl_host sgwl_host_i (.c_out(serial_clk_in), .d_out(serial_gain_bit_in),
      .w_out(load_window_n_in));
   initial forever #10 core_clk_in = ~core_clk_in;
   task chk(input int n, input logic [10:0] e);
      repeat (n) @(negedge core_clk_in);
      checks++;
      if (st !== e) $display("[ERR] %0t want %h", $time, e);
      fails += (st !== e);
   endtask : chk
   task t_boot;
      chk(12, 11'h000);
      sys_rst_in = 1'b0;
      chk(30, 11'h300);
      sgwl_host_i.send(16'h00A5, 8);
      chk(1, 11'h700);
      chk(6, 11'h3A5);
      sgwl_host_i.send(16'h03C3, 10);
      chk(7, 11'h3C3);
      $display("t_boot done");
   endtask : t_boot
   task t_sleep;
      sleep_request_n_in = 1'b0;
      chk(3, 11'h0C3);
      sgwl_host_i.send(16'h003C, 8);
      chk(7, 11'h03C);
      sleep_request_n_in = 1'b1;
      chk(6, 11'h33C);
      $display("t_sleep done");
   endtask : t_sleep
   task t_stray;
      sgwl_host_i.idle_pulses(4);
      chk(6, 11'h33C);
      sgwl_host_i.send(16'h0081, 8);
      chk(7, 11'h381);
      $display("t_stray done");
   endtask : t_stray
   task test_done(input int late);
      fails += late;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   initial begin
      t_boot;
      t_sleep;
      t_stray;
      test_done(0);
   end
   initial #100000 test_done(1);
endmodule : test_serial_gain_word_loader
`default_nettype wire
